// >>> tps_self_test.sv
`timescale 1ns/1ps
`include "tps_defs.svh"

// Summary of operation
// [R1] shifted main-keyboard 3 gives number sign (U.S.) or pound sign (U.K.)
// [R2] power-up starts on power on, set-up A reset key 0, or host reset
// [R3] every power-up sequence runs the resident self-tests
// [R4] on success cursor goes home and all four indicator lamps go off
// [R5] power-up tests fitted video memory, nonvolatile store and keyboard
// [R6] fatal error halts everything at once; lamps may show its code
// [R7] nonfatal error keeps running, forces local mode, shows error character
// [R8] five nonfatal classes: video memory, store, keyboard, loopback, modem
// [R9] loopback and modem tests run only on separate host request
// [R10] error character is ASCII zero plus the five-bit fault mask
// [R11] store checked by checksum; mismatch reports the store fault class
// [R12] reset key also clears graph memories before the power-up sequence
// [R13] fault mask and forced local held until power-up or line/local change; the code takes the change only in TPS_IDLE
module tps_self_test import tps_pkg::*; #(
   parameter int NV_WORDS = 16
) (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       CE,
   input  wire logic       POWER_ON,
   input  wire logic       SETUP_A,
   input  wire logic       KEY_VALID,
   input  wire logic [7:0] KEY_CODE,
   input  wire logic       KEY_SHIFT,
   input  wire logic       UK_CHARSET,
   input  wire logic       HOST_RESET,
   input  wire logic       LOOP_REQ,
   input  wire logic       MODEM_REQ,
   input  wire logic       LINE_LOCAL_CHANGE,
   input  wire logic       AVM_FITTED,
   input  wire logic [7:0] NV_DATA,
   input  wire logic       TEST_DONE,
   input  wire logic       TEST_PASS,
   input  wire logic       FATAL_IN,
   input  wire logic [3:0] FATAL_CODE,
   output logic      [7:0] NV_ADDR,
   output logic      [1:0] TEST_SEL,
   output logic            TEST_START,
   output logic      [3:0] LAMPS,
   output logic            CURSOR_HOME,
   output logic            GRAPH_CLEAR,
   output logic            FORCE_LOCAL,
   output logic      [7:0] ERR_CHAR,
   output logic            ERR_CHAR_VALID,
   output logic            HALTED,
   output logic      [7:0] KEY_CHAR,
   output logic            KEY_CHAR_VALID
);

   tps_regs_t r;
   tps_regs_t n;
   logic      pwr_rise;
   logic      key_rst;
   logic      trig;

   localparam logic [7:0] NV_LAST = 8'(NV_WORDS - 1);

   // ************************************************************
   // trigger decode
   // ************************************************************
   // power pin counts only once sync stages two and three agree
   assign pwr_rise = (r.pwr_sync[1] == r.pwr_sync[2]) && r.pwr_sync[2]
                     && !r.pwr_on;
   assign key_rst  = KEY_VALID && SETUP_A && (KEY_CODE == `TPS_KEY_ZERO);
   assign trig     = pwr_rise || key_rst || HOST_RESET; // R2

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [4:0] nm;
      nm = r.mask;
      n = r;
      n.home = 1'b0;
      n.gclr = 1'b0;
      n.tstart = 1'b0;
      n.kvld = 1'b0;
      n.pwr_sync = {r.pwr_sync[1:0], POWER_ON};
      if (r.pwr_sync[1] == r.pwr_sync[2]) begin
         n.pwr_on = r.pwr_sync[2];
      end
      // key path; reset key is consumed, not echoed
      if (KEY_VALID && !key_rst && r.st != TPS_HALT) begin
         n.kvld = 1'b1;
         if (KEY_SHIFT && KEY_CODE == `TPS_KEY_THREE) begin
            n.kchar = UK_CHARSET ? `TPS_CHR_POUND : `TPS_CHR_NUMBER; // R1
         end else begin
            n.kchar = KEY_CODE;
         end
      end
      case (r.st)
         TPS_IDLE: begin
            // host-only tests, never part of power-up
            if (LOOP_REQ) begin
               n.tsel = `TPS_SEL_LOOP; // R9
               n.tstart = 1'b1;
               n.st = TPS_EXT;
            end else if (MODEM_REQ) begin
               n.tsel = `TPS_SEL_MODEM; // R9
               n.tstart = 1'b1;
               n.st = TPS_EXT;
            end
         end
         TPS_CLR: begin
            // fresh start of the resident tests
            n.mask = `TPS_MASK_RST;
            n.local_f = 1'b0;
            n.evld = 1'b0;
            n.nv_addr = 8'h00;
            n.nv_ph = 1'b0;
            n.nv_sum = 8'h00;
            n.st = TPS_STORE; // R3
         end
         TPS_STORE: begin
            // two cycles a word: drive address, then take data
            n.nv_ph = !r.nv_ph;
            if (r.nv_ph) begin
               if (r.nv_addr == NV_LAST) begin
                  if (r.nv_sum != NV_DATA) begin
                     n.mask[`TPS_BIT_STORE] = 1'b1; // R11
                  end
                  n.tstart = 1'b1;
                  if (AVM_FITTED) begin
                     n.tsel = `TPS_SEL_AVM; // R5
                     n.st = TPS_AVM;
                  end else begin
                     n.tsel = `TPS_SEL_KEYS; // R5
                     n.st = TPS_KEYS;
                  end
               end else begin
                  n.nv_sum = r.nv_sum + NV_DATA; // R11
                  n.nv_addr = r.nv_addr + 8'h01;
               end
            end
         end
         TPS_AVM: begin
            if (TEST_DONE) begin
               if (!TEST_PASS) begin
                  n.mask[`TPS_BIT_AVM] = 1'b1; // R8
               end
               n.tsel = `TPS_SEL_KEYS; // R5
               n.tstart = 1'b1;
               n.st = TPS_KEYS;
            end
         end
         TPS_KEYS: begin
            if (TEST_DONE) begin
               if (!TEST_PASS) begin
                  n.mask[`TPS_BIT_KEYS] = 1'b1; // R8
               end
               n.st = TPS_DONE;
            end
         end
         TPS_DONE: begin
            if (r.mask == `TPS_MASK_RST) begin
               n.home = 1'b1; // R4
               n.lamps = `TPS_LAMPS_RST; // R4
            end else begin
               n.local_f = 1'b1; // R7
               n.evld = 1'b1; // R7
               n.echar = `TPS_ERR_BASE + {3'b000, r.mask}; // R10
            end
            n.st = TPS_IDLE;
         end
         TPS_EXT: begin
            if (TEST_DONE) begin
               if (!TEST_PASS) begin
                  if (r.tsel == `TPS_SEL_LOOP) begin
                     nm[`TPS_BIT_LOOP] = 1'b1; // R8
                  end else begin
                     nm[`TPS_BIT_MODEM] = 1'b1; // R8
                  end
                  n.mask = nm;
                  n.local_f = 1'b1; // R7
                  n.evld = 1'b1;
                  n.echar = `TPS_ERR_BASE + {3'b000, nm}; // R10
               end
               n.st = TPS_IDLE;
            end
         end
         TPS_HALT: begin
            n.st = TPS_HALT;
         end
         default: begin
            n.st = TPS_IDLE;
         end
      endcase
      // operator line/local change in TPS_IDLE drops the forced state
      if (LINE_LOCAL_CHANGE && r.st == TPS_IDLE) begin
         n.local_f = 1'b0; // R13
         n.mask = `TPS_MASK_RST; // R13
         n.evld = 1'b0;
      end
      // any trigger restarts except in TPS_HALT; a restart beats a pending test
      if (trig && r.st != TPS_HALT) begin
         n.st = TPS_CLR; // R2
         n.gclr = key_rst; // R12
         n.tstart = 1'b0;
      end
      // fatal wins over everything and never lets go
      if (FATAL_IN || r.st == TPS_HALT) begin
         // freeze every step under way, so no address or mask moves on
         n = r;
         n.st = TPS_HALT; // R6
         n.halted = 1'b1;
         n.kvld = 1'b0;
         n.home = 1'b0;
         n.gclr = 1'b0;
         n.tstart = 1'b0;
         if (FATAL_IN && r.st != TPS_HALT) begin
            n.lamps = FATAL_CODE; // R6
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= '0;
      end else if (CE) begin
         r <= n;
      end
   end

   // outputs straight from the state register
   assign NV_ADDR        = r.nv_addr;
   assign TEST_SEL       = r.tsel;
   assign TEST_START     = r.tstart;
   assign LAMPS          = r.lamps;
   assign CURSOR_HOME    = r.home;
   assign GRAPH_CLEAR    = r.gclr;
   assign FORCE_LOCAL    = r.local_f;
   assign ERR_CHAR       = r.echar;
   assign ERR_CHAR_VALID = r.evld;
   assign HALTED         = r.halted;
   assign KEY_CHAR       = r.kchar;
   assign KEY_CHAR_VALID = r.kvld;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_reset_key;
      CE && key_rst && r.st != TPS_HALT && !FATAL_IN;
   endsequence
   sequence s_cleared;
      r.st == TPS_CLR && GRAPH_CLEAR;
   endsequence

   property p_shift3;
      CE && KEY_VALID && !key_rst && KEY_SHIFT && r.st != TPS_HALT
         && !FATAL_IN && KEY_CODE == `TPS_KEY_THREE
      |=> KEY_CHAR_VALID && KEY_CHAR ==
          ($past(UK_CHARSET) ? `TPS_CHR_POUND : `TPS_CHR_NUMBER);
   endproperty
   a_shift3: assert property (p_shift3) else $error("shift 3 map"); // R1

   property p_trig;
      CE && trig && r.st != TPS_HALT && !FATAL_IN |=> r.st == TPS_CLR;
   endproperty
   a_trig: assert property (p_trig) else $error("no restart"); // R2

   property p_tests;
      CE && r.st == TPS_CLR && !trig && !FATAL_IN |=> r.st == TPS_STORE;
   endproperty
   a_tests: assert property (p_tests) else $error("tests skipped"); // R3

   property p_home;
      CE && r.st == TPS_DONE && r.mask == 5'h00 && !trig && !FATAL_IN
      |=> CURSOR_HOME && LAMPS == 4'h0 && !FORCE_LOCAL;
   endproperty
   a_home: assert property (p_home) else $error("no home"); // R4

   property p_avm_sel;
      TEST_START && $past(r.st) == TPS_STORE |->
         TEST_SEL == ($past(AVM_FITTED) ? `TPS_SEL_AVM : `TPS_SEL_KEYS);
   endproperty
   a_avm_sel: assert property (p_avm_sel) else $error("bad test"); // R5

   property p_fatal;
      CE && FATAL_IN && r.st != TPS_HALT
      |=> HALTED && LAMPS == $past(FATAL_CODE) ##1 HALTED;
   endproperty
   a_fatal: assert property (p_fatal) else $error("no halt"); // R6

   property p_nonfatal;
      CE && r.st == TPS_DONE && r.mask != 5'h00 && !trig && !FATAL_IN
      |=> FORCE_LOCAL && ERR_CHAR_VALID && !HALTED;
   endproperty
   a_nonfatal: assert property (p_nonfatal) else $error("no local"); // R7

   property p_char;
      ERR_CHAR_VALID && r.st == TPS_IDLE |->
         ERR_CHAR == 8'h30 + {3'b000, r.mask};
   endproperty
   a_char: assert property (p_char) else $error("bad error char"); // R10

   property p_no_ext;
      TEST_START && TEST_SEL inside {`TPS_SEL_LOOP, `TPS_SEL_MODEM} |->
         r.st == TPS_EXT;
   endproperty
   a_no_ext: assert property (p_no_ext) else $error("ext in power-up"); // R9

   property p_nv_bad;
      CE && r.st == TPS_STORE && r.nv_ph && r.nv_addr == NV_LAST
         && r.nv_sum != NV_DATA && !trig && !FATAL_IN
      |=> r.mask[`TPS_BIT_STORE];
   endproperty
   a_nv_bad: assert property (p_nv_bad) else $error("checksum missed"); // R11

   property p_gclr;
      s_reset_key |=> s_cleared;
   endproperty
   a_gclr: assert property (p_gclr) else $error("graph not cleared"); // R12

   property p_hold;
      CE && FORCE_LOCAL && r.st == TPS_IDLE && !LINE_LOCAL_CHANGE && !trig
         && !FATAL_IN |=> FORCE_LOCAL;
   endproperty
   a_hold: assert property (p_hold) else $error("local lost"); // R13

endmodule

// >>> tps_defs.svh
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH

// ************************************************************
// fault mask bit positions
// ************************************************************
`define TPS_BIT_AVM      0
`define TPS_BIT_STORE    1
`define TPS_BIT_KEYS     2
`define TPS_BIT_LOOP     3
`define TPS_BIT_MODEM    4

// ************************************************************
// character codes
// ************************************************************
`define TPS_ERR_BASE     8'h30
`define TPS_KEY_ZERO     8'h30
`define TPS_KEY_THREE    8'h33
`define TPS_CHR_NUMBER   8'h23
`define TPS_CHR_POUND    8'ha3

// ************************************************************
// test selector codes and reset values
// ************************************************************
`define TPS_SEL_AVM      2'h0
`define TPS_SEL_KEYS     2'h1
`define TPS_SEL_LOOP     2'h2
`define TPS_SEL_MODEM    2'h3
`define TPS_LAMPS_RST    4'h0
`define TPS_MASK_RST     5'h00

`endif

// >>> tps_pkg.sv
package tps_pkg;

   // sequencer states, gray coded from TPS_CLR through TPS_AVM to TPS_DONE
   typedef enum logic [2:0] {
      TPS_IDLE  = 3'b000,
      TPS_CLR   = 3'b001,
      TPS_STORE = 3'b011,
      TPS_AVM   = 3'b010,
      TPS_KEYS  = 3'b110,
      TPS_DONE  = 3'b111,
      TPS_EXT   = 3'b101,
      TPS_HALT  = 3'b100
   } tps_state_t;

   // complete state of the sequencer
   typedef struct packed {
      tps_state_t  st;
      logic [2:0]  pwr_sync;
      logic        pwr_on;
      logic [4:0]  mask;
      logic        local_f;
      logic [3:0]  lamps;
      logic        home;
      logic        gclr;
      logic [7:0]  echar;
      logic        evld;
      logic        halted;
      logic [1:0]  tsel;
      logic        tstart;
      logic [7:0]  nv_addr;
      logic        nv_ph;
      logic [7:0]  nv_sum;
      logic [7:0]  kchar;
      logic        kvld;
   } tps_regs_t;

endpackage

// >>> tps_far_side.sv
`timescale 1ns/1ps
// ************************************************************
// far side: settings store and test units
// ************************************************************
module tps_far_side import tps_pkg::*; #(
   parameter int NV_WORDS = 4
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] nv_addr,
   input  wire logic [1:0] test_sel,
   input  wire logic       test_start,
   input  wire logic [3:0] pass_sel,
   input  wire logic       bad_sum,
   input  wire logic [7:0] base,
   input  wire logic [2:0] dly,
   output logic      [7:0] nv_data,
   output logic            test_done,
   output logic            test_pass
);
   logic       pend;
   logic [2:0] cnt;
   logic [1:0] sel_r;

   // ramp of words from base; last word holds the sum of the rest, bit 0 flipped when bad_sum is set
   function automatic logic [7:0] word(input logic [7:0] a);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < NV_WORDS - 1; i++) s += base + 8'(3 * i);
      if (a < 8'(NV_WORDS - 1)) return base + 8'(3 * a);
      return s ^ {7'h00, bad_sum};
   endfunction

   // store answers a cycle late; a stale pass flag flips so it never lingers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_data <= 8'h00;
         test_done <= 1'b0;
         test_pass <= 1'b0;
         pend <= 1'b0;
         cnt <= 3'h0;
         sel_r <= 2'h0;
      end else begin
         nv_data <= word(nv_addr);
         test_done <= 1'b0;
         test_pass <= ~test_pass;
         if (test_start) begin
            pend <= 1'b1;
            cnt <= dly;
            sel_r <= test_sel;
         end else if (pend && cnt == 3'h0) begin
            pend <= 1'b0;
            test_done <= 1'b1;
            test_pass <= pass_sel[sel_r];
         end else if (pend) begin
            cnt <= cnt - 3'h1;
         end
      end
   end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top import tps_pkg::*;;
   localparam int NW = 4;
   logic       clk, rst_n, pwr, sa, kv, ks, uk, hr, lr, mr, llc, fit, fat;
   logic       bad, ts, td, tp, home, gclr, floc, ev, halt, kcv, hit, v, ce;
   logic [7:0] kc, base, na, nd, ech, kch, c;
   logic [3:0] fc, ps, lamps;
   logic [2:0] dly;
   logic [1:0] tsel;
   logic [1:0] sel_q[$];
   int         num_errors = 0;
   int         num_checks = 0;

   tps_self_test #(.NV_WORDS(NW)) u_dut (.CLK(clk), .RST_N(rst_n),
      .CE(ce), .POWER_ON(pwr), .SETUP_A(sa), .KEY_VALID(kv),
      .KEY_CODE(kc), .KEY_SHIFT(ks), .UK_CHARSET(uk), .HOST_RESET(hr),
      .LOOP_REQ(lr), .MODEM_REQ(mr), .LINE_LOCAL_CHANGE(llc),
      .AVM_FITTED(fit), .NV_DATA(nd), .TEST_DONE(td), .TEST_PASS(tp),
      .FATAL_IN(fat), .FATAL_CODE(fc), .NV_ADDR(na), .TEST_SEL(tsel),
      .TEST_START(ts), .LAMPS(lamps), .CURSOR_HOME(home),
      .GRAPH_CLEAR(gclr), .FORCE_LOCAL(floc), .ERR_CHAR(ech),
      .ERR_CHAR_VALID(ev), .HALTED(halt), .KEY_CHAR(kch),
      .KEY_CHAR_VALID(kcv));
   tps_far_side #(.NV_WORDS(NW)) u_far (.clk(clk), .rst_n(rst_n),
      .nv_addr(na), .test_sel(tsel), .test_start(ts), .pass_sel(ps),
      .bad_sum(bad), .base(base), .dly(dly), .nv_data(nd),
      .test_done(td), .test_pass(tp));

   // ************************************************************
   // clock, log of started tests, watchdog
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (ts === 1'b1) sel_q.push_back(tsel);
   // whole run needs a few hundred cycles; this is far beyond it
   initial begin
      #400000;
      $display("watchdog expired");
      num_errors++;
      tally_and_finish();
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input string w, input logic [7:0] s, e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   // condition is looked at before waiting: a one-cycle pulse may be up
   task automatic wait_start(input logic [1:0] s);
      hit = ts === 1'b1 && tsel === s;
      for (int i = 0; i < 300 && !hit; i++) begin
         tick(1);
         hit = ts === 1'b1 && tsel === s;
      end
      check("test start", hit, 1);
   endtask
   task automatic wait_end();
      hit = home === 1'b1 || ev === 1'b1;
      for (int i = 0; i < 300 && !hit; i++) begin
         tick(1);
         hit = home === 1'b1 || ev === 1'b1;
      end
      check("sequence end", hit, 1);
   endtask
   function automatic logic [4:0] exp_mask(bit f, logic [3:0] p, bit b);
      return {2'b00, ~p[1], b, f & ~p[0]};
   endfunction
   task automatic pwr_check(input bit f, input logic [3:0] p, input bit b);
      logic [4:0] m;
      m = exp_mask(f, p, b);
      wait_start(2'h1);
      wait_end();
      check("cursor home", home, m == 0);
      if (m == 0) check("lamps off", lamps, 0);
      check("forced local", floc, m != 0);
      if (m != 0) check("error char", ech, 8'h30 + m);
      check("tests run", 8'(sel_q.size()), f ? 2 : 1);
      check("first test", sel_q[0], f ? 0 : 1);
      tick(10);
      check("local held", floc, m != 0);
      sel_q.delete();
   endtask
   task automatic host_test(ref logic rq, input logic [1:0] s,
                            input logic [7:0] c);
      pulse(rq);
      wait_start(s);
      for (int i = 0; i < 20 && td !== 1'b1; i++) tick(1);
      tick(1);
      check("host test char", ech, c);
      check("host test local", floc, 1);
      sel_q.delete();
   endtask
   task automatic key(input logic [7:0] k, input logic s);
      kc = k;
      ks = s;
      kv = 1'b1;
      tick(1);
      kv = 1'b0;
      v = kcv;
      c = kch;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {pwr, sa, kv, ks, uk, hr, lr, mr, llc, fat, bad} = '0;
      {kc, fc, dly, base} = '0;
      rst_n = 1'b0;
      fit = 1'b1;
      ce = 1'b1;
      ps = 4'hf;
      void'($urandom(80));
      pwr = 1'b1;
      tick(3);
      rst_n = 1'b1;
      pwr_check(1, ps, 0);
      $display("power on done");
      ps = 4'h0;
      host_test(lr, 2'h2, 8'h38);
      host_test(mr, 2'h3, 8'h48);
      pulse(llc);
      check("line local clears", floc, 0);
      check("line local char off", ev, 0);
      host_test(mr, 2'h3, 8'h40);
      $display("host tests done");
      for (int i = 0; i < 8; i++) begin
         fit = 1'($urandom % 2);
         ps = 4'($urandom);
         bad = (i < 2) ? i[0] : 1'($urandom % 2);
         base = 8'($urandom);
         dly = 3'($urandom % 5);
         if (i % 2) pulse(hr);
         else begin
            pwr = 1'b0;
            tick(5);
            pwr = 1'b1;
         end
         pwr_check(fit, ps, bad);
      end
      $display("random power-ups done");
      sa = 1'b1;
      key(8'h30, 1'b0);
      check("reset key echo", v, 0);
      for (int i = 0; i < 6 && gclr !== 1'b1; i++) tick(1);
      check("graph clear", gclr, 1);
      sa = 1'b0;
      pwr_check(fit, ps, bad);
      $display("reset key done");
      // both sets, shifted and plain; a spare edge keeps strobes apart
      for (int i = 0; i < 4; i++) begin
         uk = i[0];
         tick(1);
         key(8'h33, !i[1]);
         check("key valid", v, 1);
         check("shift three", c, i[1] ? 8'h33 : (uk ? 8'ha3 : 8'h23));
      end
      $display("charset done");
      // clock enable low: a key and a host reset must leave no trace
      tick(1);
      ce = 1'b0;
      key(8'h33, 1'b1);
      check("frozen key", v, 0);
      pulse(hr);
      tick(2);
      ce = 1'b1;
      tick(20);
      check("frozen restart", 8'(sel_q.size()), 0);
      $display("freeze done");
      fc = 4'($urandom);
      fat = 1'b1;
      tick(1);
      fat = 1'b0;
      check("halted", halt, 1);
      check("fatal lamps", lamps, fc);
      pulse(hr);
      tick(20);
      check("still halted", halt, 1);
      check("no test in halt", 8'(sel_q.size()), 0);
      $display("fatal done");
      tally_and_finish();
   end
endmodule
